// ---- shared/msd_pkg.sv ----
// constants for the multiply, shift and saturate datapath
package msd_pkg;

	// operand, product and bus widths
	localparam int OP_W   = 16;
	localparam int PROD_W = 32;
	localparam int ADDR_W = 4;

	// register word addresses on the plain register port
	localparam logic [3:0] ADDR_STAT0   = 4'h0;
	localparam logic [3:0] ADDR_STAT1   = 4'h1;
	localparam logic [3:0] ADDR_OPND_A  = 4'h2;
	localparam logic [3:0] ADDR_OPND_B  = 4'h3;
	localparam logic [3:0] ADDR_CMD     = 4'h4;
	localparam logic [3:0] ADDR_PROD_LO = 4'h5;
	localparam logic [3:0] ADDR_PROD_HI = 4'h6;
	localparam logic [3:0] ADDR_ACC_LO  = 4'h7;
	localparam logic [3:0] ADDR_ACC_HI  = 4'h8;
	localparam logic [3:0] ADDR_DWB     = 4'h9;
	localparam logic [3:0] ADDR_IRQ_ST  = 4'hA;
	localparam logic [3:0] ADDR_IRQ_MSK = 4'hB;

	// status word zero fields
	localparam int SW0_SAT_BIT = 11;
	localparam int SW0_OVF_BIT = 12;
	// status word one fields
	localparam int SW1_PSEL_LO = 0;
	localparam int SW1_PSEL_HI = 1;

	// command word fields
	localparam int CMD_OP_LO   = 0;
	localparam int CMD_OP_HI   = 2;
	localparam int CMD_SIGNED  = 3;
	localparam int CMD_CNT_LO  = 4;
	localparam int CMD_CNT_HI  = 6;
	localparam int CMD_HALF    = 7;

	// command operation codes
	localparam logic [2:0] OP_NONE  = 3'h0;
	localparam logic [2:0] OP_MPY   = 3'h1;
	localparam logic [2:0] OP_LDP   = 3'h2;
	localparam logic [2:0] OP_ADDP  = 3'h3;
	localparam logic [2:0] OP_SUBP  = 3'h4;
	localparam logic [2:0] OP_STORE = 3'h5;

	// product shift select encodings
	localparam logic [1:0] PSEL_NONE = 2'h0;
	localparam logic [1:0] PSEL_L1   = 2'h1;
	localparam logic [1:0] PSEL_L4   = 2'h2;
	localparam logic [1:0] PSEL_R6   = 2'h3;

	// interrupt event bits
	localparam int IRQ_OVF   = 0;
	localparam int IRQ_MPY   = 1;
	localparam int IRQ_STORE = 2;
	localparam int IRQ_W     = 3;

	// saturation limits and reset values
	localparam logic [31:0] ACC_MAX_POS = 32'h7FFFFFFF;
	localparam logic [31:0] ACC_MAX_NEG = 32'h80000000;
	localparam logic [15:0] SW0_RESET   = 16'h0000;
	localparam logic [1:0]  PSEL_RESET  = 2'h0;

endpackage : msd_pkg

// ---- hdl/msd_prod_shift.sv ----
// four-mode product shifter between product register and accumulator
module msd_prod_shift (
	// product and mode
	input  wire logic [31:0] product,
	input  wire logic [1:0]  product_shift_select,
	// shifted result
	output logic      [31:0] shifted
);

	// mode decode; right shift keeps the sign
	always_comb begin
		case (product_shift_select)
			msd_pkg::PSEL_NONE: shifted = product;
			msd_pkg::PSEL_L1:   shifted = {product[30:0], 1'b0};
			msd_pkg::PSEL_L4:   shifted = {product[27:0], 4'h0};
			msd_pkg::PSEL_R6:   shifted = {{6{product[31]}}, product[31:6]};
			default:            shifted = product;
		endcase
	end

endmodule // msd_prod_shift

// ---- hdl/msd_out_shift.sv ----
// left barrel shifter, accumulator down to one 16-bit half
module msd_out_shift (
	// accumulator and controls
	input  wire logic [31:0] acc,
	input  wire logic [2:0]  count,
	input  wire logic        high_half,
	// selected half
	output logic      [15:0] half_out
);

	logic [31:0] acc_shl; // shifted accumulator, upper bits dropped

	// shift then pick a half
	always_comb begin
		acc_shl  = acc << count;
		half_out = high_half ? acc_shl[31:16] : acc_shl[15:0];
	end

endmodule // msd_out_shift

// ---- hdl/msd_datapath.sv ----
// Notes on behaviour
// - 16x16 multiply, signed or unsigned, 32-bit result
// - product register holds until next multiply
// - product shifter: none, left 1, left 4, right 6
// - output shift 0..7 left, high or low half
// - saturation loads most positive or most negative
// - overflow flag at bit 12 of status zero
// - bit 11 of status zero enables saturation
// - shift select in status one bits 1:0
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
module msd_datapath (
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        srst,
	// register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	// data write bus
	output logic      [15:0] data_write_bus,
	output logic             data_write_valid,
	// interrupt
	output logic             irq
);

	// software visible state
	logic [15:0] opnd_a_q;             // multiplicand
	logic [15:0] opnd_b_q;             // multiplier
	logic        saturation_enable_q;  // overflow handling mode
	logic        acc_overflow_flag_q;  // sticky overflow
	logic [1:0]  product_shift_select_q; // product shifter mode
	logic [31:0] product_result_reg_q; // last multiply result
	logic [31:0] acc_q;                // accumulator
	logic [2:0]  irq_status_q;         // sticky events
	logic [2:0]  irq_mask_q;           // event enables

	// output and read registers
	logic [15:0] reg_rdata_q;          // read data, one cycle late
	logic [15:0] dwb_q;                // data write bus value
	logic        dwb_valid_q;          // store strobe
	logic        irq_q;                // registered interrupt

	// command decode
	logic        cmd_wr;               // a command word arrives
	logic [2:0]  cmd_op;               // its operation
	logic        cmd_signed;           // signed multiply request
	logic [2:0]  cmd_count;            // output shift count
	logic        cmd_high;             // select upper half

	// datapath nets
	logic [31:0] mpy_result;           // raw multiplier output
	logic [31:0] prod_shifted;         // product shifter output
	logic [15:0] out_half;             // output shifter output
	logic [32:0] acc_sum;              // one guard bit above acc
	logic        acc_ovf;              // result left the 32-bit range
	logic [31:0] acc_next;             // value to load after an op
	logic        acc_op;               // load, add or subtract

	// events raised this cycle
	logic        ev_ovf;
	logic        ev_mpy;
	logic        ev_store;
	logic [2:0]  ev_clr;               // status bits written with one

	// split the command word into its fields
	always_comb begin
		cmd_wr     = reg_wr && (reg_addr == msd_pkg::ADDR_CMD);
		cmd_op     = reg_wdata[msd_pkg::CMD_OP_HI:msd_pkg::CMD_OP_LO];
		cmd_signed = reg_wdata[msd_pkg::CMD_SIGNED];
		cmd_count  = reg_wdata[msd_pkg::CMD_CNT_HI:msd_pkg::CMD_CNT_LO];
		cmd_high   = reg_wdata[msd_pkg::CMD_HALF];
	end

	// multiplier; one extra bit gives a clean unsigned case
	// signed or unsigned multiply
	always_comb begin
		logic signed [16:0] ext_a;
		logic signed [16:0] ext_b;
		logic signed [33:0] full;
		ext_a = '0;
		ext_b = '0;
		full  = '0;
		if (cmd_signed) begin
			ext_a = {opnd_a_q[15], opnd_a_q};
			ext_b = {opnd_b_q[15], opnd_b_q};
		end else begin
			ext_a = {1'b0, opnd_a_q};
			ext_b = {1'b0, opnd_b_q};
		end
		full       = ext_a * ext_b;
		mpy_result = full[31:0];
	end

	// product shifter sits between product register and accumulator
	// four shift modes
	msd_prod_shift u_prod_shift (
		.product              (product_result_reg_q),
		.product_shift_select (product_shift_select_q),
		.shifted              (prod_shifted)
	);

	// output shifter feeds the data write bus
	// shift then pick half
	msd_out_shift u_out_shift (
		.acc       (acc_q),
		.count     (cmd_count),
		.high_half (cmd_high),
		.half_out  (out_half)
	);

	// accumulator arithmetic with one guard bit for overflow
	always_comb begin
		acc_op  = cmd_wr && ((cmd_op == msd_pkg::OP_LDP) ||
			(cmd_op == msd_pkg::OP_ADDP) || (cmd_op == msd_pkg::OP_SUBP));
		acc_sum = {prod_shifted[31], prod_shifted};
		if (cmd_op == msd_pkg::OP_ADDP) begin
			acc_sum = {acc_q[31], acc_q} +
				{prod_shifted[31], prod_shifted};
		end else if (cmd_op == msd_pkg::OP_SUBP) begin
			acc_sum = {acc_q[31], acc_q} -
				{prod_shifted[31], prod_shifted};
		end
		// guard and sign differ only when the range was left
		// detect overflow
		acc_ovf = acc_op && (acc_sum[32] != acc_sum[31]);
	end

	// choose the loaded value; the guard bit tells the direction
	always_comb begin
		acc_next = acc_sum[31:0];
		if (acc_ovf && saturation_enable_q) begin
			if (acc_sum[32]) begin
				acc_next = msd_pkg::ACC_MAX_NEG;
			end else begin
				acc_next = msd_pkg::ACC_MAX_POS;
			end
		end
	end

	// events for the interrupt status
	always_comb begin
		ev_ovf   = acc_ovf;
		ev_mpy   = cmd_wr && (cmd_op == msd_pkg::OP_MPY);
		ev_store = cmd_wr && (cmd_op == msd_pkg::OP_STORE);
		// write-one-to-clear pattern for the interrupt status
		ev_clr   = 3'h0;
		if (reg_wr && (reg_addr == msd_pkg::ADDR_IRQ_ST)) begin
			ev_clr = reg_wdata[msd_pkg::IRQ_W-1:0];
		end
	end

	// operand registers
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			opnd_a_q <= 16'h0000;
			opnd_b_q <= 16'h0000;
		end else if (reg_wr) begin
			// only the two operand addresses load them
			if (reg_addr == msd_pkg::ADDR_OPND_A) begin
				opnd_a_q <= reg_wdata;
			end
			if (reg_addr == msd_pkg::ADDR_OPND_B) begin
				opnd_b_q <= reg_wdata;
			end
		end
	end

	// product register changes only on a multiply command
	// capture and hold
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			product_result_reg_q <= 32'h00000000;
		end else if (ev_mpy) begin
			product_result_reg_q <= mpy_result;
		end
	end

	// accumulator: command result, or direct software load
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			acc_q <= 32'h00000000;
		end else if (acc_op) begin
			acc_q <= acc_next;
		end else if (reg_wr && (reg_addr == msd_pkg::ADDR_ACC_LO)) begin
			acc_q[15:0] <= reg_wdata;
		end else if (reg_wr && (reg_addr == msd_pkg::ADDR_ACC_HI)) begin
			acc_q[31:16] <= reg_wdata;
		end
	end

	// saturation mode bit in status word zero
	// mode control bit
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			saturation_enable_q <= msd_pkg::SW0_RESET[msd_pkg::SW0_SAT_BIT];
		end else if (reg_wr && (reg_addr == msd_pkg::ADDR_STAT0)) begin
			saturation_enable_q <= reg_wdata[msd_pkg::SW0_SAT_BIT];
		end
	end

	// overflow flag is sticky; a new overflow beats a clear
	// set on overflow
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			acc_overflow_flag_q <= msd_pkg::SW0_RESET[msd_pkg::SW0_OVF_BIT];
		end else if (ev_ovf) begin
			acc_overflow_flag_q <= 1'b1;
		end else if (reg_wr && (reg_addr == msd_pkg::ADDR_STAT0) &&
			reg_wdata[msd_pkg::SW0_OVF_BIT]) begin
			// writing one clears, as for the interrupt bits
			acc_overflow_flag_q <= 1'b0;
		end
	end

	// product shift select field of status word one
	// bits 1:0 of status one
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			product_shift_select_q <= msd_pkg::PSEL_RESET;
		end else if (reg_wr && (reg_addr == msd_pkg::ADDR_STAT1)) begin
			product_shift_select_q <=
				reg_wdata[msd_pkg::SW1_PSEL_HI:msd_pkg::SW1_PSEL_LO];
		end
	end

	// store command drives one half onto the data write bus
	// drive data write bus
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			dwb_q       <= 16'h0000;
			dwb_valid_q <= 1'b0;
		end else begin
			// strobe lasts one cycle, data holds until next store
			dwb_valid_q <= ev_store;
			if (ev_store) begin
				dwb_q <= out_half;
			end
		end
	end

	// interrupt status: each event sets, writing one clears, set wins
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			irq_status_q <= 3'h0;
		end else begin
			// a set in the same cycle as its clear survives
			irq_status_q <= (irq_status_q & ~ev_clr) |
				{ev_store, ev_mpy, ev_ovf};
		end
	end

	// interrupt mask, same layout as the status
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			irq_mask_q <= 3'h0;
		end else if (reg_wr && (reg_addr == msd_pkg::ADDR_IRQ_MSK)) begin
			irq_mask_q <= reg_wdata[msd_pkg::IRQ_W-1:0];
		end
	end

	// level interrupt, registered so it comes from a flop;
	// it trails the status by one cycle
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(irq_status_q & irq_mask_q);
		end
	end

	// read data valid only the cycle after the strobe, else zero
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			reg_rdata_q <= 16'h0000;
		end else if (reg_rd) begin
			case (reg_addr)
				msd_pkg::ADDR_STAT0: begin
					reg_rdata_q <= 16'h0000;
					reg_rdata_q[msd_pkg::SW0_SAT_BIT] <= saturation_enable_q;
					reg_rdata_q[msd_pkg::SW0_OVF_BIT] <= acc_overflow_flag_q;
				end
				msd_pkg::ADDR_STAT1: begin
					reg_rdata_q <= {14'h0000, product_shift_select_q};
				end
				msd_pkg::ADDR_OPND_A:  reg_rdata_q <= opnd_a_q;
				msd_pkg::ADDR_OPND_B:  reg_rdata_q <= opnd_b_q;
				msd_pkg::ADDR_PROD_LO: begin
					reg_rdata_q <= product_result_reg_q[15:0];
				end
				msd_pkg::ADDR_PROD_HI: begin
					reg_rdata_q <= product_result_reg_q[31:16];
				end
				msd_pkg::ADDR_ACC_LO:  reg_rdata_q <= acc_q[15:0];
				msd_pkg::ADDR_ACC_HI:  reg_rdata_q <= acc_q[31:16];
				msd_pkg::ADDR_DWB:     reg_rdata_q <= dwb_q;
				msd_pkg::ADDR_IRQ_ST:  begin
					reg_rdata_q <= {13'h0000, irq_status_q};
				end
				msd_pkg::ADDR_IRQ_MSK: begin
					reg_rdata_q <= {13'h0000, irq_mask_q};
				end
				// unmapped and command address read as zero
				default:               reg_rdata_q <= 16'h0000;
			endcase
		end else begin
			reg_rdata_q <= 16'h0000;
		end
	end

	// outputs straight from flops
	always_comb begin
		reg_rdata        = reg_rdata_q;
		data_write_bus   = dwb_q;
		data_write_valid = dwb_valid_q;
		irq              = irq_q;
	end

endmodule // msd_datapath

// ---- test/msd_checker_assertions.sv ----
// port-level checker for the datapath; sees only the top ports
module msd_checker (
	// clock and reset
	input wire logic        sys_clk,
	input wire logic        srst,
	// register port
	input wire logic [3:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_rdata,
	// data write bus and interrupt
	input wire logic [15:0] data_write_bus,
	input wire logic        data_write_valid,
	input wire logic        irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	// store command seen on the command word
	logic st_cmd;
	assign st_cmd = reg_wr && reg_addr == msd_pkg::ADDR_CMD
		&& reg_wdata[2:0] == msd_pkg::OP_STORE;

	a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
		else $error("read data not zero outside read answer");
	a_read_unmapped: assert property (reg_rd && reg_addr > 4'hB
		|=> reg_rdata == 16'h0000)
		else $error("unmapped read returned data");
	a_store_pulse: assert property (st_cmd |=> data_write_valid)
		else $error("no write valid after store");
	a_valid_cause: assert property (data_write_valid |-> $past(st_cmd))
		else $error("write valid without store");
	a_bus_hold: assert property (!data_write_valid |-> $stable(data_write_bus))
		else $error("data write bus moved without store");
	a_sat_readback: assert property (
		(reg_wr && reg_addr == msd_pkg::ADDR_STAT0) ##1 !reg_wr
		##1 (reg_rd && reg_addr == msd_pkg::ADDR_STAT0)
		|=> reg_rdata[11] == $past(reg_wdata[11], 3))
		else $error("saturation enable readback wrong");
	a_psel_readback: assert property (
		(reg_wr && reg_addr == msd_pkg::ADDR_STAT1) ##1 !reg_wr
		##1 (reg_rd && reg_addr == msd_pkg::ADDR_STAT1)
		|=> reg_rdata[1:0] == $past(reg_wdata[1:0], 3))
		else $error("shift select readback wrong");
	a_prod_stable: assert property (
		(reg_rd && reg_addr == msd_pkg::ADDR_PROD_LO) ##1 !reg_wr
		##1 (reg_rd && reg_addr == msd_pkg::ADDR_PROD_LO)
		|=> reg_rdata == $past(reg_rdata, 2))
		else $error("product changed without multiply");
	a_irq_masked: assert property (
		(reg_wr && reg_addr == msd_pkg::ADDR_IRQ_MSK && reg_wdata[2:0] == 3'h0)
		##1 !(reg_wr && reg_addr == msd_pkg::ADDR_IRQ_MSK) |-> ##1 !irq)
		else $error("interrupt high with all masked");
endmodule // msd_checker

bind msd_datapath msd_checker msd_checker_i (.sys_clk(sys_clk),
	.srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.data_write_bus(data_write_bus), .data_write_valid(data_write_valid),
	.irq(irq));

// ---- test/msd_datapath_bench.sv ----
// compare a value seen against the value worked out here
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin \
	fail_count++; $display("MISMATCH %s exp %h got %h", n, e, g); end end

module msd_datapath_bench;
	timeunit 1ns;
	timeprecision 1ps;
	// stimulus, all given at time zero
	logic        sys_clk = 1'b0;
	logic        srst = 1'b1;
	logic [3:0]  reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	// observed outputs
	logic [15:0] reg_rdata;
	logic [15:0] data_write_bus;
	logic        data_write_valid;
	logic        irq;
	// bookkeeping and scratch values
	int          fail_count = 0;
	int          check_count = 0;
	int          cycles = 0;
	logic [15:0] rd_v;
	logic        wv;
	logic [31:0] pr;
	logic [31:0] sh;
	logic [15:0] sc [3] = '{16'h00C5, 16'h0005, 16'h0075};

	always #2 sys_clk = ~sys_clk;

	msd_datapath msd_datapath_i (.sys_clk(sys_clk), .srst(srst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.data_write_bus(data_write_bus),
		.data_write_valid(data_write_valid), .irq(irq));

	// one-cycle write; valid is sampled in the following cycle
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
		@(negedge sys_clk);
		wv = data_write_valid;
		@(posedge sys_clk);
	endtask
	// one-cycle read; data stand only in the next cycle
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		d = reg_rdata;
		@(posedge sys_clk);
	endtask
	// 32-bit value as two independent words, low first
	task automatic chk32(input logic [3:0] a, input logic [31:0] e);
		logic [15:0] lo;
		logic [15:0] hi;
		rd(a, lo);
		rd(a + 4'h1, hi);
		`CHK("pair", e, {hi, lo})
	endtask
	// product shifter as the modes define it
	function automatic logic [31:0] psh(input logic [1:0] m,
		input logic [31:0] p);
		case (m)
			2'h1: return p << 1;
			2'h2: return p << 4;
			2'h3: return $signed(p) >>> 6;
			default: return p;
		endcase
	endfunction
	// verdict, reached from the end of the tests or the timeout
	task automatic close_out;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// hang guard: tests need well under a thousand cycles
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			fail_count++;
			close_out();
		end
	end

	initial begin
		repeat (3) @(posedge sys_clk);
		srst <= 1'b0;
		rd(msd_pkg::ADDR_STAT0, rd_v);
		`CHK("stat0", 16'h0000, rd_v)
		rd(msd_pkg::ADDR_STAT1, rd_v);
		`CHK("stat1", 16'h0000, rd_v)
		rd(4'hF, rd_v);
		`CHK("unmapped", 16'h0000, rd_v)
		$display("reset test done");
		// unsigned then signed on the same operands
		wr(msd_pkg::ADDR_OPND_A, 16'hFFFF);
		wr(msd_pkg::ADDR_OPND_B, 16'hFFFF);
		wr(msd_pkg::ADDR_CMD, 16'h0001);
		chk32(msd_pkg::ADDR_PROD_LO, 32'hFFFE0001);
		wr(msd_pkg::ADDR_CMD, 16'h0009);
		chk32(msd_pkg::ADDR_PROD_LO, 32'h00000001);
		wr(msd_pkg::ADDR_OPND_A, 16'h8000);
		wr(msd_pkg::ADDR_OPND_B, 16'h7FFF);
		wr(msd_pkg::ADDR_CMD, 16'h0009);
		rd(msd_pkg::ADDR_PROD_LO, rd_v);
		rd(msd_pkg::ADDR_PROD_LO, rd_v);
		`CHK("prod_lo", 16'h8000, rd_v)
		rd(msd_pkg::ADDR_OPND_A, rd_v);
		`CHK("opnd_a", 16'h8000, rd_v)
		rd(msd_pkg::ADDR_OPND_B, rd_v);
		`CHK("opnd_b", 16'h7FFF, rd_v)
		rd(msd_pkg::ADDR_CMD, rd_v);
		`CHK("cmd_rd", 16'h0000, rd_v)
		$display("multiply test done");
		// every shift mode loaded into the accumulator
		for (int m = 0; m < 4; m++) begin
			wr(msd_pkg::ADDR_STAT1, 16'(m));
			rd(msd_pkg::ADDR_STAT1, rd_v);
			`CHK("psel", 16'(m), rd_v)
			wr(msd_pkg::ADDR_CMD, 16'h0002);
			chk32(msd_pkg::ADDR_ACC_LO, psh(2'(m), 32'hC0008000));
		end
		$display("shift test done");
		// wrap, then saturate both ways
		wr(msd_pkg::ADDR_OPND_A, 16'h7FFF);
		wr(msd_pkg::ADDR_OPND_B, 16'h7FFF);
		wr(msd_pkg::ADDR_CMD, 16'h0009);
		wr(msd_pkg::ADDR_STAT1, 16'h0001);
		wr(msd_pkg::ADDR_CMD, 16'h0002);
		wr(msd_pkg::ADDR_CMD, 16'h0003);
		chk32(msd_pkg::ADDR_ACC_LO, 32'hFFFC0004);
		rd(msd_pkg::ADDR_STAT0, rd_v);
		`CHK("stat0", 16'h1000, rd_v)
		wr(msd_pkg::ADDR_STAT0, 16'h1800);
		rd(msd_pkg::ADDR_STAT0, rd_v);
		`CHK("stat0", 16'h0800, rd_v)
		wr(msd_pkg::ADDR_CMD, 16'h0002);
		wr(msd_pkg::ADDR_CMD, 16'h0003);
		chk32(msd_pkg::ADDR_ACC_LO, 32'h7FFFFFFF);
		wr(msd_pkg::ADDR_ACC_HI, 16'h8000);
		wr(msd_pkg::ADDR_ACC_LO, 16'h0000);
		wr(msd_pkg::ADDR_CMD, 16'h0004);
		chk32(msd_pkg::ADDR_ACC_LO, 32'h80000000);
		rd(msd_pkg::ADDR_STAT0, rd_v);
		`CHK("stat0", 16'h1800, rd_v)
		$display("overflow test done");
		// store with edge counts and both halves
		wr(msd_pkg::ADDR_ACC_HI, 16'h1234);
		wr(msd_pkg::ADDR_ACC_LO, 16'h5678);
		for (int i = 0; i < 3; i++) begin
			sh = 32'h12345678 << sc[i][6:4];
			wr(msd_pkg::ADDR_CMD, sc[i]);
			`CHK("valid", 1'b1, wv)
			`CHK("dwb", sc[i][7] ? sh[31:16] : sh[15:0], data_write_bus)
			rd(msd_pkg::ADDR_DWB, rd_v);
			`CHK("dwb_reg", sc[i][7] ? sh[31:16] : sh[15:0], rd_v)
		end
		$display("store test done");
		// raise, mask, clear, raise again
		wr(msd_pkg::ADDR_IRQ_MSK, 16'h0007);
		rd(msd_pkg::ADDR_IRQ_ST, rd_v);
		`CHK("irq_st", 16'h0007, rd_v)
		`CHK("irq", 1'b1, irq)
		wr(msd_pkg::ADDR_IRQ_MSK, 16'h0000);
		rd(msd_pkg::ADDR_IRQ_MSK, rd_v);
		`CHK("irq", 1'b0, irq)
		wr(msd_pkg::ADDR_IRQ_MSK, 16'h0004);
		wr(msd_pkg::ADDR_IRQ_ST, 16'h0007);
		rd(msd_pkg::ADDR_IRQ_ST, rd_v);
		`CHK("irq_st", 16'h0000, rd_v)
		`CHK("irq", 1'b0, irq)
		wr(msd_pkg::ADDR_CMD, 16'h0005);
		rd(msd_pkg::ADDR_IRQ_ST, rd_v);
		`CHK("irq_st", 16'h0004, rd_v)
		`CHK("irq", 1'b1, irq)
		$display("interrupt test done");
		close_out();
	end
endmodule // msd_datapath_bench
